/* core/tone_source.sv */
// Notes on behaviour
// R1: Two tone outputs, each a 1 kHz sine when enabled and not overridden.
// R2: Either output can be picked by its source-select code for a mixer input.
// R3: Software adds rate conversion when routing to chains at another rate.
// R4: Bits 9:8 advance tone B by 0, 90, 180 or 270 degrees; reset 00.
// R5: Bit 5 switches output B from tone to DC level; reset 0.
// R6: Bit 4 switches output A from tone to DC level; reset 0.
// R7: Under override an output streams its own 24-bit DC level.
// R8: Bit 1 enables output B; reset 0, disabled.
// R9: Bit 0 enables output A; reset 0.
// R10: DC levels are two's complement, 4 integer and 20 fraction bits.
// R11: Disabled outputs give zero; enabled ones give one sample per rate tick.
//
// Dual tone and DC test source with a register port and a buffered mixer stream.
// Assumes sampleTick pulses at the 48 kHz tone rate and waits while tickReady is low.
// Assumes the register strobes and the tick all come from logic on this clock.
`timescale 1ns/1ps
`include "tone_source_map.svh"

module tone_source
	import tone_source_pkg::*;
(
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Register port.
	input  wire logic         regWrite,
	input  wire logic         regRead,
	input  wire reg_addr_t    regAddr,
	input  wire logic [31:0]  regWrData,
	output logic [31:0]       regRdData,
	// Sample rate timing.
	input  wire logic         sampleTick,
	output logic              tickReady,
	// Direct tone outputs.
	output sample_t           toneASample,
	output sample_t           toneBSample,
	// Mixer input stream.
	input  wire source_code_t mixerSourceSelect,
	output logic              mixValid,
	input  wire logic         mixReady,
	output sample_t           mixData
);
	logic [31:0] toneSourceControl;
	sample_t     toneADcLevel;
	sample_t     toneBDcLevel;
	phase_t      phase;

	localparam int CHANNELS = 2;

	wire toneAEnable     = toneSourceControl[`TONE_A_EN_BIT];
	wire toneBEnable     = toneSourceControl[`TONE_B_EN_BIT];
	wire toneADcOverride = toneSourceControl[`TONE_A_OVD_BIT];
	wire toneBDcOverride = toneSourceControl[`TONE_B_OVD_BIT];
	wire [1:0] toneOffset = toneSourceControl[`TONE_OFS_MSB:`TONE_OFS_LSB];

	// One-hot decode of the register map, shared by the write and read paths so both agree.
	function automatic logic [2:0] slotHit(input reg_addr_t addr);
		logic [2:0] hit;
		hit = 3'h0;
		unique case (addr)
			`TONE_CTRL_OFFSET:  hit = 3'h1;
			`TONE_A_LVL_OFFSET: hit = 3'h2;
			`TONE_B_LVL_OFFSET: hit = 3'h4;
			default:            hit = 3'h0;
		endcase
		slotHit = hit;
	endfunction

	wire [2:0] regHit  = slotHit(regAddr);
	wire       hitCtrl = regHit[0];
	wire       hitLvlA = regHit[1];
	wire       hitLvlB = regHit[2];

	// Only the documented control fields are writable; all other bits read as zero.
	wire [31:0] ctrlWriteMask = 32'h0000_0333;

	// Quarter-wave table at full scale, 7.5 degree steps, so 48 steps make one 1 kHz cycle.
	function automatic sample_t quarterWave(input logic [3:0] k);
		unique case (k)
			4'h0: quarterWave = 24'h000000;
			4'h1: quarterWave = 24'h0216a2;
			4'h2: quarterWave = 24'h04241f;
			4'h3: quarterWave = 24'h061f79;
			4'h4: quarterWave = 24'h080000;
			4'h5: quarterWave = 24'h09bd7b;
			4'h6: quarterWave = 24'h0b504f;
			4'h7: quarterWave = 24'h0cb194;
			4'h8: quarterWave = 24'h0ddb3d;
			4'h9: quarterWave = 24'h0ec836;
			4'ha: quarterWave = 24'h0f746e;
			4'hb: quarterWave = 24'h0fdcf6;
			4'hc: quarterWave = 24'h100000;
			default: quarterWave = 24'h000000;
		endcase
	endfunction

	// Full sine from a phase step 0..47, folding the quarter table by quadrant.
	function automatic sample_t sineAt(input phase_t p);
		logic [1:0] quad;
		logic [3:0] rem;
		sample_t    mag;
		quad = 2'h0;
		rem  = 4'h0;
		mag  = '0;
		if (p >= 6'h24) begin
			quad = 2'h3;
			rem  = 4'(p - 6'h24);
		end else if (p >= 6'h18) begin
			quad = 2'h2;
			rem  = 4'(p - 6'h18);
		end else if (p >= `TONE_QUARTER) begin
			quad = 2'h1;
			rem  = 4'(p - `TONE_QUARTER);
		end else begin
			rem  = 4'(p);
		end
		mag = quarterWave(quad[0] ? 4'(4'hc - rem) : rem);
		sineAt = quad[1] ? 24'(-mag) : mag;
	endfunction

	// Tone B leads tone A by whole quarter cycles, wrapping at 48 steps.
	wire [6:0] phaseBSum = {1'b0, phase} + {1'b0, 6'(toneOffset * `TONE_QUARTER)}; // R4
	wire phase_t phaseB  = (phaseBSum >= {1'b0, `TONE_STEPS}) ?
		6'(phaseBSum - {1'b0, `TONE_STEPS}) : phaseBSum[5:0]; // R4

	// Per-output view of the controls, index 0 for output A and 1 for output B.
	logic    chanEnable   [CHANNELS];
	logic    chanOverride [CHANNELS];
	sample_t chanLevel    [CHANNELS];
	phase_t  chanPhase    [CHANNELS];
	sample_t chanNext     [CHANNELS];

	assign chanEnable[0]   = toneAEnable; // R9
	assign chanEnable[1]   = toneBEnable; // R8
	assign chanOverride[0] = toneADcOverride; // R6
	assign chanOverride[1] = toneBDcOverride; // R5
	assign chanLevel[0]    = toneADcLevel; // R7
	assign chanLevel[1]    = toneBDcLevel; // R7
	assign chanPhase[0]    = phase; // R1
	assign chanPhase[1]    = phaseB; // R4

	// A disabled output gives silence, not its last sample, so no mixer hears a stuck level.
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChannel
		assign chanNext[ch] = !chanEnable[ch] ? 24'h000000 : // R8 R9 R11
			chanOverride[ch] ? chanLevel[ch] : sineAt(chanPhase[ch]); // R1 R5 R6 R7 R10
	end

	wire sample_t nextA = chanNext[0]; // R1
	wire sample_t nextB = chanNext[1]; // R1

	// The stream runs at the tick rate; a chain at another rate needs its own converter.
	wire selA = (mixerSourceSelect == `SRC_TONE_A); // R2
	wire selB = (mixerSourceSelect == `SRC_TONE_B); // R2
	wire sample_t mixNext = selA ? nextA : (selB ? nextB : 24'h000000); // R2

	// A tick is taken only when the buffer has room, so no sample is dropped under stall.
	wire takeTick = sampleTick && tickReady; // R11
	wire anyOn    = toneAEnable || toneBEnable;

	wire [31:0] readMux = hitCtrl ? toneSourceControl :
		hitLvlA ? {8'h00, toneADcLevel} :
		hitLvlB ? {8'h00, toneBDcLevel} : 32'h0000_0000;

	// Level writes keep bits 23:0; the upper byte has no storage and reads back as zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toneSourceControl <= `TONE_CTRL_RESET; // R4 R5 R6 R8 R9
			toneADcLevel      <= `TONE_LVL_RESET;
			toneBDcLevel      <= `TONE_LVL_RESET;
		end else if (regWrite) begin
			if (hitCtrl) toneSourceControl <= regWrData & ctrlWriteMask;
			if (hitLvlA) toneADcLevel <= regWrData[23:0]; // R7
			if (hitLvlB) toneBDcLevel <= regWrData[23:0]; // R7
		end
	end

	// Read data is registered and holds until the next read, so the master may take it late.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 32'h0000_0000;
		end else if (regRead) begin
			regRdData <= readMux;
		end
	end

	// Phase restarts when both outputs are off so the offset always starts from a known point.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 6'h00;
		end else if (!anyOn) begin
			phase <= 6'h00;
		end else if (takeTick) begin
			phase <= (phase == `TONE_STEPS - 6'h01) ? 6'h00 : 6'(phase + 6'h01); // R1 R11
		end
	end

	// Samples move only on a taken tick, so a refused tick leaves outputs and phase alone.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toneASample <= 24'h000000;
			toneBSample <= 24'h000000;
		end else if (takeTick) begin
			toneASample <= nextA; // R11
			toneBSample <= nextB; // R11
		end
	end

	// The buffer takes its word on the tick's own edge, so stream and tone ports stay aligned.
	sample_buffer #(
		.WIDTH(24)
	) mixBuffer (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (sampleTick),
		.inReady  (tickReady),
		.inData   (mixNext),
		.outValid (mixValid),
		.outReady (mixReady),
		.outData  (mixData)
	);
endmodule // tone_source

/* core/tone_source_map.svh */
// Register offsets, field positions, reset values and source codes of the tone source.
// Assumes inclusion by the package and the design files only.
`ifndef TONE_SOURCE_MAP_SVH
`define TONE_SOURCE_MAP_SVH

`define TONE_CTRL_OFFSET   16'hb000
`define TONE_A_LVL_OFFSET  16'hb004
`define TONE_B_LVL_OFFSET  16'hb008

`define TONE_A_EN_BIT      0
`define TONE_B_EN_BIT      1
`define TONE_A_OVD_BIT     4
`define TONE_B_OVD_BIT     5
`define TONE_OFS_LSB       8
`define TONE_OFS_MSB       9

`define TONE_CTRL_RESET    32'h0000_0000
`define TONE_LVL_RESET     24'h10_0000

`define TONE_STEPS         6'h30
`define TONE_QUARTER       6'h0c

`define SRC_TONE_A         9'h004
`define SRC_TONE_B         9'h005

`endif

/* core/tone_source_pkg.sv */
// Types shared by the tone source design files.
// Assumes the map header sits beside it in core/.
`include "tone_source_map.svh"

package tone_source_pkg;
	typedef logic [23:0] sample_t;
	typedef logic [8:0]  source_code_t;
	typedef logic [5:0]  phase_t;
	typedef logic [15:0] reg_addr_t;
endpackage

/* core/sample_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module sample_buffer #(
	parameter int WIDTH = 24
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side.
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	logic [WIDTH-1:0] slot [2];
	logic             wrPtr;
	logic             rdPtr;
	logic [1:0]       count;
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;

	// A word can enter only while a slot is free, so a stalled receiver holds back the source.
	assign inReady  = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData  = slot[rdPtr];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
			slot[0] <= '0;
			slot[1] <= '0;
		end else begin
			if (doWrite) begin
				slot[wrPtr] <= inData;
				wrPtr <= ~wrPtr;
			end
			if (doRead) begin
				rdPtr <= ~rdPtr;
			end
			count <= count + {1'b0, doWrite} - {1'b0, doRead};
		end
	end
endmodule // sample_buffer

/* tb/tone_source_sva.sv */
// Port assertions for the tone source.
// Assumes binding to tone_source; helpers copy the control word and level A.
`timescale 1ns/1ps
module tone_source_sva
	import tone_source_pkg::*;
(
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port.
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire reg_addr_t   regAddr,
	input wire logic [31:0] regWrData,
	input wire logic [31:0] regRdData,
	// Stream.
	input wire logic        sampleTick,
	input wire logic        tickReady,
	input wire sample_t     toneASample,
	input wire sample_t     toneBSample,
	input wire logic        mixValid,
	input wire logic        mixReady,
	input wire sample_t     mixData
);
	logic [31:0] ctl;
	sample_t     lvlA;
	wire         taken = sampleTick && tickReady;
	wire         mapped = regAddr inside {16'hb000, 16'hb004, 16'hb008};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= 32'h0;
			lvlA <= 24'h10_0000;
		end else if (regWrite && regAddr == 16'hb000) begin
			ctl <= regWrData;
		end else if (regWrite && regAddr == 16'hb004) begin
			lvlA <= regWrData[23:0];
		end
	end
	ctl_read_a: assert property (regRead && regAddr == 16'hb000 && !regWrite
		|=> regRdData == (ctl & 32'h333)) else $error("control read wrong");
	unmapped_read_a: assert property (regRead && !mapped |=> regRdData == 32'h0) else $error("unmapped read");
	a_off_a: assert property (taken && !ctl[0] |=> toneASample == 24'h0) else $error("A not zero");
	b_off_a: assert property (taken && !ctl[1] |=> toneBSample == 24'h0) else $error("B not zero");
	a_level_a: assert property (taken && ctl[0] && ctl[4] |=> toneASample == lvlA) else $error("A level");
	tick_push_a: assert property (taken |=> mixValid) else $error("word lost");
	mix_hold_a: assert property (mixValid && !mixReady |=> mixValid && $stable(mixData)) else $error("head moved");
	full_valid_a: assert property (!tickReady |-> mixValid) else $error("refused while empty");
	refused_hold_a: assert property (sampleTick && !tickReady |=> $stable(toneASample) && $stable(toneBSample))
		else $error("refused tick moved samples");
	cover property (sampleTick && !tickReady);
	cover property (taken && ctl[4] && ctl[5]);
	cover property (regRead && regAddr == 16'hb000);
endmodule // tone_source_sva
bind tone_source tone_source_sva chk_u (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
	.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .sampleTick(sampleTick),
	.tickReady(tickReady), .toneASample(toneASample), .toneBSample(toneBSample), .mixValid(mixValid),
	.mixReady(mixReady), .mixData(mixData));

/* tb/mixer_sink.sv */
// Mixer input model: takes stream words into a queue.
// Assumes the bench sets the pace and empties the queue.
`timescale 1ns/1ps
module mixer_sink
	import tone_source_pkg::*;
(
	// Clock and reset.
	input  wire logic    clk,
	input  wire logic    rst_n,
	// Pace.
	input  wire logic    stall,
	input  wire logic    slow,
	// Stream.
	input  wire logic    mixValid,
	output logic         mixReady,
	input  wire sample_t mixData
);
	sample_t got[$];
	// A slow mixer is ready every other cycle, so the buffer both fills and drains.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mixReady <= 1'b0;
		end else begin
			mixReady <= !stall && (!slow || !mixReady);
			if (mixValid && mixReady) got.push_back(mixData);
		end
	end
endmodule // mixer_sink

/* tb/tone_source_tb_top.sv */
// Bench for the tone source: register and tick tasks, mixer model.
// Assumes the core/ files and tb/mixer_sink.sv.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("mismatch %0t %h %h", $time, (g), (e)); end end
module tone_source_tb_top
	import tone_source_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, sampleTick = 1'b0, stall = 1'b0, slow = 1'b0;
	logic         tickReady, mixValid, mixReady;
	reg_addr_t    regAddr = 16'h0;
	logic [31:0]  regWrData = 32'h0, regRdData;
	sample_t      toneASample, toneBSample, mixData, x, y, a[48], b[48];
	source_code_t mixerSourceSelect = 9'h004;
	int           failures = 0, checks_done = 0, k, o;
	always #2.5 clk = ~clk;
	tone_source dut_u (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .sampleTick(sampleTick), .tickReady(tickReady),
		.toneASample(toneASample), .toneBSample(toneBSample), .mixerSourceSelect(mixerSourceSelect),
		.mixValid(mixValid), .mixReady(mixReady), .mixData(mixData));
	mixer_sink sink_u (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow), .mixValid(mixValid),
		.mixReady(mixReady), .mixData(mixData));
	task automatic wr(input reg_addr_t ad, input logic [31:0] d);
		@(posedge clk);
		{regWrite, regAddr, regWrData} <= {1'b1, ad, d};
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input reg_addr_t ad, input logic [31:0] e);
		@(posedge clk);
		{regRead, regAddr} <= {1'b1, ad};
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		`CHK(regRdData, e)
	endtask
	// A refused tick stays raised until it is taken or 200 cycles pass.
	task automatic tick(output sample_t sa, output sample_t sb);
		logic r;
		@(posedge clk);
		sampleTick <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(negedge clk);
			r = tickReady;
			@(posedge clk);
			if (r === 1'b1) break;
		end
		if (r !== 1'b1) failures++;
		sampleTick <= 1'b0;
		@(negedge clk);
		{sa, sb} = {toneASample, toneBSample};
	endtask
	task automatic drain;
		for (int n = 0; n < 200 && mixValid !== 1'b0; n++) @(posedge clk);
		if (mixValid !== 1'b0) failures++;
	endtask
	task automatic complete_run;
		if (failures == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'hb000, 32'h0);
		rd(16'hb004, 32'h10_0000);
		rd(16'hb008, 32'h10_0000);
		rd(16'hb00c, 32'h0);
		wr(16'hb000, 32'hffff_ffff);
		rd(16'hb000, 32'h333);
		wr(16'hb000, 32'h0);
		tick(x, y);
		`CHK({x, y}, 48'h0)
		// Ticks and mixer share one rate, so no rate converter sits between them.
		for (o = 0; o < 4; o++) begin
			drain();
			sink_u.got.delete();
			mixerSourceSelect <= o[0] ? 9'h005 : 9'h004;
			{slow, stall} <= {o[1], o == 3};
			wr(16'hb000, {22'h0, o[1:0], 8'h03});
			fork begin repeat (40) @(posedge clk); stall <= 1'b0; end join_none
			for (k = 0; k < 48; k++) tick(a[k], b[k]);
			drain();
			`CHK(a[0], 24'h0)
			`CHK(a[12], 24'h10_0000)
			`CHK(a[36], -a[12])
			`CHK(sink_u.got.size(), 48)
			for (k = 0; k < 48; k++) begin
				`CHK(b[k], a[(k + 12 * o) % 48])
				`CHK(sink_u.got[k], o[0] ? b[k] : a[k])
			end
			wr(16'hb000, 32'h0);
		end
		wr(16'hb004, 32'h00f0_0000);
		wr(16'hb008, 32'h0008_0000);
		wr(16'hb000, 32'h33);
		tick(x, y);
		`CHK(x, 24'hf0_0000)
		`CHK(y, 24'h08_0000)
		drain();
		sink_u.got.delete();
		mixerSourceSelect <= 9'h006;
		tick(x, y);
		drain();
		`CHK(sink_u.got[0], 24'h0)
		// A reset in mid-run must bring every control back to its disabled default.
		wr(16'hb000, 32'h333);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'hb000, 32'h0);
		rd(16'hb004, 32'h10_0000);
		tick(x, y);
		`CHK({x, y}, 48'h0)
		complete_run();
	end
endmodule // tone_source_tb_top
